// file: inc/phy_control_params.svh
// constants for the phy control register and its management engine
`ifndef PHY_CONTROL_PARAMS_SVH
`define PHY_CONTROL_PARAMS_SVH

// register map
`define PHYCTL_ADDR 5'h00
`define PHYCTL_RESET 16'h3100
`define PHYCTL_WR_MASK 16'hFF80
`define PHYCTL_RD_NONE 16'h0000
`define CTL_SOFT_MASK 16'h8000
`define CTL_RESTART_MASK 16'h0200

// bit positions
`define CTL_SOFT_RESET 15
`define CTL_LOOPBACK 14
`define CTL_SPEED 13
`define CTL_AN_ENABLE 12
`define CTL_LOW_POWER 11
`define CTL_ISOLATE 10
`define CTL_AN_RESTART 9
`define CTL_DUPLEX 8
`define CTL_COL_TEST 7

// management frame
`define MDIO_PREAMBLE 6'h20
`define MDIO_OP_READ 2'h2
`define MDIO_OP_WRITE 2'h1
`define MDIO_HDR_LAST 5'h0B
`define MDIO_DATA_LAST 5'h0F

`endif

// file: inc/phy_control_pkg.sv
// types for the phy control register and its management engine
package phy_control_pkg;

  typedef enum logic [2:0] {
    MS_HUNT,
    MS_START,
    MS_HDR,
    MS_TA,
    MS_DATA
  } mdio_state_t;

  typedef enum logic {
    SR_IDLE,
    SR_BUSY
  } soft_reset_state_t;

endpackage : phy_control_pkg

// file: inc/mgmt_if.sv
// register access between the management engine and the register file
`timescale 1ns/1ps
`default_nettype none

interface mgmt_if;
  logic wr_pulse;
  logic [4:0] addr;
  logic [15:0] wr_data;
  logic [15:0] rd_data;

  modport engine (
    output wr_pulse,
    output addr,
    output wr_data,
    input rd_data
  );

  modport regfile (
    input wr_pulse,
    input addr,
    input wr_data,
    output rd_data
  );
endinterface : mgmt_if

`default_nettype wire

// file: logic/mdio_engine.sv
// serial management frame engine sampling the management clock
`timescale 1ns/1ps
`default_nettype none
`include "phy_control_params.svh"

module mdio_engine #(
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // management pins
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  // register file side
  mgmt_if.engine regs
);

  phy_control_pkg::mdio_state_t state;
  logic mdc_meta;
  logic mdc_sync;
  logic mdc_prev;
  logic mdio_meta;
  logic mdio_sync;
  logic [5:0] ones;
  logic [4:0] cnt;
  logic [11:0] hdr;
  logic [15:0] shift;
  logic is_read;

  wire rise = mdc_sync & ~mdc_prev;
  wire bit_in = mdio_sync;
  wire [11:0] next_hdr = {hdr[10:0], bit_in};
  wire [15:0] next_shift = {shift[14:0], bit_in};
  wire [4:0] next_cnt = cnt + 5'h01;
  wire op_ok = (next_hdr[11:10] == `MDIO_OP_READ) ||
               (next_hdr[11:10] == `MDIO_OP_WRITE);
  wire addr_ok = next_hdr[9:5] == PHY_ADDR;
  wire pre_ok = ones == `MDIO_PREAMBLE;

  always_ff @(posedge core_clk)
  begin
    mdc_meta <= mdc;
    mdc_sync <= mdc_meta;
    mdc_prev <= mdc_sync;
    mdio_meta <= mdio_in;
    mdio_sync <= mdio_meta;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state <= phy_control_pkg::MS_HUNT;
      ones <= 6'h00;
      cnt <= 5'h00;
      hdr <= 12'h000;
      shift <= 16'h0000;
      is_read <= 1'h0;
      mdio_out <= 1'h0;
      mdio_oe <= 1'h0;
      regs.wr_pulse <= 1'h0;
      regs.addr <= 5'h00;
      regs.wr_data <= 16'h0000;
    end
    else
    begin
      regs.wr_pulse <= 1'h0;
      if (rise)
      begin
        unique case (state)
          phy_control_pkg::MS_HUNT:
          begin
            if (bit_in)
              ones <= pre_ok ? ones : ones + 6'h01;
            else
            begin
              ones <= 6'h00;
              if (pre_ok)
                state <= phy_control_pkg::MS_START;
            end
          end
          phy_control_pkg::MS_START:
          begin
            cnt <= 5'h00;
            state <= bit_in ? phy_control_pkg::MS_HDR
                            : phy_control_pkg::MS_HUNT;
          end
          phy_control_pkg::MS_HDR:
          begin
            hdr <= next_hdr;
            cnt <= next_cnt;
            if (cnt == `MDIO_HDR_LAST)
            begin
              cnt <= 5'h00;
              is_read <= next_hdr[11:10] == `MDIO_OP_READ;
              regs.addr <= next_hdr[4:0];
              state <= (op_ok && addr_ok) ? phy_control_pkg::MS_TA
                                          : phy_control_pkg::MS_HUNT;
            end
          end
          phy_control_pkg::MS_TA:
          begin
            cnt <= next_cnt;
            if (!cnt[0])
            begin
              // second turnaround bit is driven low on reads
              mdio_oe <= is_read;
              mdio_out <= 1'h0;
            end
            else
            begin
              cnt <= 5'h00;
              shift <= regs.rd_data;
              mdio_out <= is_read & regs.rd_data[15];
              state <= phy_control_pkg::MS_DATA;
            end
          end
          phy_control_pkg::MS_DATA:
          begin
            cnt <= next_cnt;
            shift <= next_shift;
            mdio_out <= is_read & shift[14];
            if (cnt == `MDIO_DATA_LAST)
            begin
              mdio_oe <= 1'h0;
              mdio_out <= 1'h0;
              regs.wr_pulse <= !is_read;
              regs.wr_data <= next_shift;
              state <= phy_control_pkg::MS_HUNT;
            end
          end
        endcase
      end
    end
  end

endmodule : mdio_engine

`default_nettype wire

// file: logic/phy_control_register.sv
// phy control register with soft reset, loopback, isolate and test paths
`timescale 1ns/1ps
`default_nettype none
`include "phy_control_params.svh"

module phy_control_register #(
  parameter logic [4:0] PHY_ADDR = 5'h01,
  parameter int SOFT_RESET_CYCLES = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // serial management pins
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  // mac side media independent interface
  input wire logic mac_tx_en,
  input wire logic [3:0] mac_txd,
  output logic mac_rx_dv,
  output logic [3:0] mac_rxd,
  output logic mac_crs,
  output logic mac_col,
  // medium side transceiver
  output logic line_tx_en,
  output logic [3:0] line_txd,
  input wire logic line_rx_dv,
  input wire logic [3:0] line_rxd,
  input wire logic line_crs,
  input wire logic line_col,
  // negotiation result
  input wire logic an_full_duplex,
  // control outputs to the phy core
  output logic speed_100,
  output logic full_duplex,
  output logic autoneg_enable,
  output logic low_power_enable,
  output logic isolate,
  output logic autoneg_restart,
  output logic soft_reset
);

  localparam logic [15:0] SR_LAST = 16'(SOFT_RESET_CYCLES - 1);
  localparam int SR_BOUND = SOFT_RESET_CYCLES + 1;

  mgmt_if mgmt ();

  logic [15:0] ctrl;
  logic [15:0] sr_cnt;
  phy_control_pkg::soft_reset_state_t sr_state;

  mdio_engine #(
    .PHY_ADDR(PHY_ADDR)
  ) u_engine (
    .core_clk(core_clk),
    .rst(rst),
    .mdc(mdc),
    .mdio_in(mdio_in),
    .mdio_out(mdio_out),
    .mdio_oe(mdio_oe),
    .regs(mgmt.engine)
  );

  // register decode
  wire addr_hit = mgmt.addr == `PHYCTL_ADDR;
  wire sr_idle = sr_state == phy_control_pkg::SR_IDLE;
  wire sr_busy = sr_state == phy_control_pkg::SR_BUSY;
  wire wr_hit = mgmt.wr_pulse && addr_hit && sr_idle;
  wire sr_start = wr_hit && mgmt.wr_data[`CTL_SOFT_RESET];
  wire sr_done = sr_busy && (sr_cnt == SR_LAST);
  wire restart_clr = ctrl[`CTL_AN_RESTART] && sr_idle;
  wire [15:0] wr_value = mgmt.wr_data & `PHYCTL_WR_MASK;
  wire [15:0] next_ctrl =
    sr_start ? (`PHYCTL_RESET | `CTL_SOFT_MASK) :
    sr_done ? `PHYCTL_RESET :
    sr_busy ? ctrl :
    wr_hit ? wr_value :
    restart_clr ? (ctrl & ~`CTL_RESTART_MASK) :
    ctrl;

  assign mgmt.rd_data = addr_hit ? ctrl : `PHYCTL_RD_NONE;

  always_ff @(posedge core_clk)
  begin
    if (rst)
      ctrl <= `PHYCTL_RESET;
    else
      ctrl <= next_ctrl;
  end

  // soft reset sequencer
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sr_state <= phy_control_pkg::SR_IDLE;
      sr_cnt <= 16'h0000;
    end
    else
    begin
      unique case (sr_state)
        phy_control_pkg::SR_IDLE:
        begin
          sr_cnt <= 16'h0000;
          if (sr_start)
            sr_state <= phy_control_pkg::SR_BUSY;
        end
        phy_control_pkg::SR_BUSY:
        begin
          sr_cnt <= sr_cnt + 16'h0001;
          if (sr_done)
            sr_state <= phy_control_pkg::SR_IDLE;
        end
      endcase
    end
  end

  // data path selection
  wire path_off = ctrl[`CTL_ISOLATE] | ctrl[`CTL_LOW_POWER] | soft_reset;
  wire loop = ctrl[`CTL_LOOPBACK];
  wire col_test = ctrl[`CTL_COL_TEST];
  wire next_line_tx_en = mac_tx_en & ~path_off & ~loop;
  wire [3:0] next_line_txd = next_line_tx_en ? mac_txd : 4'h0;
  wire next_rx_dv = !path_off && (loop ? mac_tx_en : line_rx_dv);
  wire [3:0] rx_src = loop ? mac_txd : line_rxd;
  wire [3:0] next_rxd = next_rx_dv ? rx_src : 4'h0;
  wire next_crs = !path_off && (loop ? mac_tx_en : line_crs);
  wire col_src = col_test ? mac_tx_en : (!loop && line_col);
  wire next_col = !path_off && col_src;
  wire next_duplex = ctrl[`CTL_AN_ENABLE] ? an_full_duplex
                                          : ctrl[`CTL_DUPLEX];

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      line_tx_en <= 1'h0;
      line_txd <= 4'h0;
      mac_rx_dv <= 1'h0;
      mac_rxd <= 4'h0;
      mac_crs <= 1'h0;
      mac_col <= 1'h0;
      full_duplex <= 1'h1;
      autoneg_restart <= 1'h0;
      soft_reset <= 1'h0;
    end
    else
    begin
      line_tx_en <= next_line_tx_en;
      line_txd <= next_line_txd;
      mac_rx_dv <= next_rx_dv;
      mac_rxd <= next_rxd;
      mac_crs <= next_crs;
      mac_col <= next_col;
      full_duplex <= next_duplex;
      autoneg_restart <= restart_clr;
      soft_reset <= sr_start | (sr_busy & ~sr_done);
    end
  end

  // configuration taken straight from the register bits
  assign speed_100 = ctrl[`CTL_SPEED];
  assign autoneg_enable = ctrl[`CTL_AN_ENABLE];
  assign low_power_enable = ctrl[`CTL_LOW_POWER];
  assign isolate = ctrl[`CTL_ISOLATE];

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence sr_start_s;
    wr_hit && mgmt.wr_data[`CTL_SOFT_RESET];
  endsequence

  sequence sr_done_s;
    ctrl[`CTL_SOFT_RESET] && soft_reset ##[1:SR_BOUND]
      !ctrl[`CTL_SOFT_RESET];
  endsequence

  chk_reset_value: assert property (
    disable iff (1'h0) rst |=> ctrl == `PHYCTL_RESET)
    else $error("control register not at default after reset");

  chk_reserved_zero: assert property (
    (ctrl & ~`PHYCTL_WR_MASK) == `PHYCTL_RD_NONE &&
      ((mgmt.rd_data & ~`PHYCTL_WR_MASK) == `PHYCTL_RD_NONE))
    else $error("reserved control bits not zero");

  chk_soft_reset_done: assert property (
    sr_start_s |=> sr_done_s)
    else $error("soft reset bit not cleared in time");

  chk_soft_reset_defaults: assert property (
    $fell(ctrl[`CTL_SOFT_RESET]) |-> ctrl == `PHYCTL_RESET && !soft_reset)
    else $error("soft reset did not restore defaults");

  chk_loopback_line_quiet: assert property (
    loop |=> !line_tx_en)
    else $error("medium driven during loopback");

  chk_loopback_rx_path: assert property (
    (loop && !path_off) |=> mac_rx_dv == $past(mac_tx_en))
    else $error("loopback receive does not follow transmit");

  chk_col_test_follow: assert property (
    (col_test && !path_off) |=> mac_col == $past(mac_tx_en))
    else $error("collision test does not follow transmit");

  chk_restart_self_clear: assert property (
    (ctrl[`CTL_AN_RESTART] && sr_idle && !wr_hit) |=>
      autoneg_restart && !ctrl[`CTL_AN_RESTART])
    else $error("restart bit not pulsed and cleared");

  chk_isolate_quiet: assert property (
    ctrl[`CTL_ISOLATE] |=> !mac_rx_dv && !line_tx_en && !mac_col)
    else $error("data moved while isolated");

  chk_duplex_manual: assert property (
    !ctrl[`CTL_AN_ENABLE] |=> full_duplex == $past(ctrl[`CTL_DUPLEX]))
    else $error("manual duplex not applied");

endmodule : phy_control_register

`default_nettype wire

// file: testbench/mdio_master.sv
// management master model for the serial management pins
`timescale 1ns/1ps
`default_nettype none

module mdio_master (
  // serial management pins
  output logic mdc,
  output logic mdio_in,
  input wire logic mdio_out,
  input wire logic mdio_oe
);
  logic drv = 1'b1;
  logic drv_en = 1'b0;

  // line has a pull-up, so a released bus reads one
  assign mdio_in = mdio_oe ? mdio_out : (drv_en ? drv : 1'b1);

  initial mdc = 1'b0;

  // data changes while the clock is low and is sampled at its rise
  task automatic slot(input logic b, input logic en, output logic s);
    drv = b;
    drv_en = en;
    #80 mdc = 1'b1;
    s = mdio_in;
    #80 mdc = 1'b0;
  endtask : slot

  task automatic frame(input logic [1:0] op, input logic [4:0] pa,
      input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic s;
    hdr = {2'b01, op, pa, ra};
    repeat (32) slot(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--)
      slot(hdr[i], 1'b1, s);
    slot(1'b1, op == 2'h1, s);
    slot(1'b0, op == 2'h1, s);
    for (int i = 15; i >= 0; i--)
    begin
      slot(wd[i], op == 2'h1, s);
      rd[i] = s;
    end
    drv_en = 1'b0;
  endtask : frame
endmodule : mdio_master

`default_nettype wire

// file: testbench/testbench.sv
// testbench for the phy control register
`timescale 1ns/1ps
`default_nettype none
`include "phy_control_params.svh"

module testbench;
  localparam int SRC = 4;
  localparam logic [143:0] MODES = {16'h3100, 16'h3000, 16'h0100,
      16'h0000, 16'h7100, 16'h3180, 16'h7180, 16'h3500, 16'h3900};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic mdc, mdio_in, mdio_out, mdio_oe;
  logic mac_tx_en = 1'b0, line_rx_dv = 1'b0, line_crs = 1'b0;
  logic line_col = 1'b0, an_full_duplex = 1'b0;
  logic [3:0] mac_txd = 4'h0, line_rxd = 4'h0;
  logic mac_rx_dv, mac_crs, mac_col, line_tx_en;
  logic [3:0] mac_rxd, line_txd;
  logic speed_100, full_duplex, autoneg_enable, low_power_enable, isolate;
  logic autoneg_restart, soft_reset;
  logic [15:0] rd;
  int err_count = 0, cmp_count = 0, cycles = 0, seed = 76484;
  int pulses = 0, busy = 0, p0;

  always #5 core_clk = ~core_clk;

  phy_control_register #(.SOFT_RESET_CYCLES(SRC)) phy_control_register_i (
    .core_clk(core_clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mac_tx_en(mac_tx_en),
    .mac_txd(mac_txd), .mac_rx_dv(mac_rx_dv), .mac_rxd(mac_rxd),
    .mac_crs(mac_crs), .mac_col(mac_col), .line_tx_en(line_tx_en),
    .line_txd(line_txd), .line_rx_dv(line_rx_dv), .line_rxd(line_rxd),
    .line_crs(line_crs), .line_col(line_col),
    .an_full_duplex(an_full_duplex), .speed_100(speed_100),
    .full_duplex(full_duplex), .autoneg_enable(autoneg_enable),
    .low_power_enable(low_power_enable), .isolate(isolate),
    .autoneg_restart(autoneg_restart), .soft_reset(soft_reset)
  );

  mdio_master mdio_master_i (
    .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe)
  );

  task automatic end_sim;
    $display("comparisons %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    pulses <= pulses + autoneg_restart;
    busy <= busy + soft_reset;
    if (cycles == 50000)
    begin
      err_count++;
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, got);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [15:0] d);
    mdio_master_i.frame(`MDIO_OP_WRITE, 5'h01, 5'h00, d, rd);
    repeat (8) @(posedge core_clk);
  endtask : wr

  task automatic rdr(input logic [4:0] pa, ra);
    mdio_master_i.frame(`MDIO_OP_READ, pa, ra, 16'h0000, rd);
  endtask : rdr

  // expected mac and line outputs for one set of inputs
  function automatic logic [11:0] path(input logic [15:0] c,
      input logic [11:0] i);
    logic col;
    logic dv;
    col = c[7] ? i[11] : (c[14] ? 1'b0 : i[0]);
    dv = c[14] ? i[11] : i[6];
    if (c[11] | c[10])
      return 12'h000;
    // nibbles read zero while their valid is low
    if (c[14])
      return {dv, i[10:7] & {4{dv}}, i[11], col, 5'h00};
    return {dv, i[5:2] & {4{dv}}, i[1], col, i[11], i[10:7] & {4{i[11]}}};
  endfunction : path

  function automatic logic [15:0] lvl(input logic [15:0] c);
    return {12'h000, c[13:10]};
  endfunction : lvl

  task automatic mode(input logic [15:0] c);
    logic [11:0] v;
    wr(c | (16'h007F & 16'($random(seed))));
    rdr(5'h01, 5'h00);
    chk("control", c, rd);
    chk("levels", lvl(c), {12'h000, speed_100, autoneg_enable,
        low_power_enable, isolate});
    repeat (12)
    begin
      v = 12'($random(seed));
      @(posedge core_clk);
      {mac_tx_en, mac_txd, line_rx_dv, line_rxd, line_crs, line_col} <= v;
      an_full_duplex <= v[3];
      @(posedge core_clk);
      #1;
      chk("data path", {4'h0, path(c, v)}, {4'h0, mac_rx_dv, mac_rxd,
          mac_crs, mac_col, line_tx_en, line_txd});
      chk("duplex", {15'h0000, c[12] ? v[3] : c[8]},
          {15'h0000, full_duplex});
    end
  endtask : mode

  initial
  begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("reset levels", 16'h0030, {10'h000, speed_100, autoneg_enable,
        low_power_enable, isolate, autoneg_restart, soft_reset});
    rdr(5'h01, 5'h00);
    chk("reset value", 16'h3100, rd);
    rdr(5'h01, 5'h03);
    chk("other address", 16'h0000, rd);
    rdr(5'h02, 5'h00);
    chk("foreign phy", 16'hFFFF, rd);
    for (int k = 8; k >= 0; k--)
      mode(MODES[k*16 +: 16]);
    p0 = pulses;
    wr(16'h3300);
    chk("restart pulses", 16'h0001, 16'(pulses - p0));
    rdr(5'h01, 5'h00);
    chk("restart clear", 16'h3100, rd);
    wr(16'h7D80);
    p0 = busy;
    wr(16'h8000);
    chk("soft reset span", 16'(SRC), 16'(busy - p0));
    rdr(5'h01, 5'h00);
    chk("soft reset", 16'h3100, rd);
    chk("soft levels", lvl(16'h3100), {12'h000, speed_100,
        autoneg_enable, low_power_enable, isolate});
    end_sim();
  end
endmodule : testbench

`default_nettype wire
